// file: verilog/chp_pkg.sv
/*
  chp_pkg: shared constants and types for the card host port, card end and
  host end. Assumes a single 25 MHz clock on both ends.
*/
`default_nettype none
package chp_pkg;
  localparam int CLK_NS        = 40;
  localparam int ADDR_W        = 11;
  localparam int DATA_W        = 16;
  // card timing
  localparam int RST_PROC_NS   = 2000;
  localparam int IRQ_PULSE_NS  = 200;
  // host strobe timing
  localparam int SETUP_NS      = 40;
  localparam int STROBE_NS     = 160;
  localparam int RST_PROC_CYC  = (RST_PROC_NS + CLK_NS - 1) / CLK_NS;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // attribute space
  localparam logic [10:0] COR_ADDR = 11'h200;
  localparam logic [10:0] CSR_ADDR = 11'h202;
  localparam int          CIS_WORDS = 8;
  localparam int          COR_SRST_BIT = 7;
  localparam int          COR_LVL_BIT  = 6;
  localparam int          COR_IDX_MSB  = 5;
  localparam logic [7:0]  COR_RST      = 8'h00;
  localparam int          CSR_INTR_BIT = 1;
  // host controller registers (byte offsets)
  localparam logic [4:0] H_CTRL  = 5'h00;
  localparam logic [4:0] H_ADDR  = 5'h04;
  localparam logic [4:0] H_WDATA = 5'h08;
  localparam logic [4:0] H_CMD   = 5'h0C;
  localparam logic [4:0] H_STAT  = 5'h10;
  localparam logic [4:0] H_IRQS  = 5'h14;
  localparam logic [4:0] H_IRQM  = 5'h18;
  localparam int CTRL_IDE_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_IO_BIT  = 2;
  localparam int CTRL_DMA_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int ADDR_ATTR_BIT = 16;
  localparam int CMD_RD_BIT    = 0;
  localparam int CMD_WR_BIT    = 1;
  localparam int IRQ_W         = 4;

  typedef enum logic [2:0] {
    CHP_MEM = 3'b001,
    CHP_IO  = 3'b010,
    CHP_IDE = 3'b100
  } chp_mode_type;

  typedef enum logic [4:0] {
    HS_IDLE   = 5'b00001,
    HS_WAIT   = 5'b00010,
    HS_SETUP  = 5'b00100,
    HS_STROBE = 5'b01000,
    HS_HOLD   = 5'b10000
  } chp_hstate_type;
endpackage
`default_nettype wire

// file: verilog/chp_link_if.sv
/*
  chp_link_if: the pins between host end and card end, with the shared data
  bus resolved from the two enables. Assumes a pull-up on the data lines.
*/
`timescale 1ns/100ps
`default_nettype none
interface chp_link_if;
  import chp_pkg::*;
  logic                ce_n;
  logic                oe_n;
  logic                we_n;
  logic                reg_n;
  logic [ADDR_W-1:0]   addr;
  logic                card_reset;
  logic                ide_mode_select_n;
  logic                dma_grant_n;
  logic [DATA_W-1:0]   d_host;
  logic                d_host_oe;
  logic [DATA_W-1:0]   d_card;
  logic                d_card_oe;
  logic                ready_busy_n;
  logic                ide_interrupt_request;
  logic                dma_request_out;
  logic [DATA_W-1:0]   d_bus;

  assign d_bus = d_card_oe ? d_card : (d_host_oe ? d_host : 16'hFFFF);

  modport device (
    input  ce_n, oe_n, we_n, reg_n, addr, card_reset, ide_mode_select_n, dma_grant_n, d_bus,
    output d_card, d_card_oe, ready_busy_n, ide_interrupt_request, dma_request_out
  );
  modport host (
    input  ready_busy_n, ide_interrupt_request, dma_request_out, d_bus,
    output ce_n, oe_n, we_n, reg_n, addr, card_reset, ide_mode_select_n, dma_grant_n, d_host, d_host_oe
  );
endinterface
`default_nettype wire

// file: verilog/chp_card_end.sv
/*
  chp_card_end: control side of the card's parallel host port: mode pick,
  ready/busy and interrupt pin, attribute and common memory reads, DMA
  request, hardware and soft reset. Assumes pins synchronous to clk.
*/
// The Avalon-MM slave port and the address map were decided locally.
// Behaviour
// - memory mode: read strobe drives read data
// - i/o mode: read strobe reads attribute only
// - host grounds select pin for ide mode
// - memory mode: ready high, busy low
// - busy held through reset processing
// - host makes no access while busy
// - reset pin never released: stay ready
// - i/o configured: pin becomes interrupt request
// - i/o interrupt: pulse or level low
// - ide interrupt request active high
// - attribute select high common, low attribute
// - host holds attribute select low in i/o
// - grant input low confirms dma request
// - memory/io: high reset pin resets card
// - pin high since power-up: one reset
// - soft reset bit resets card
// - ide: reset pin active low
// - ide: request dma, wait for grant
`timescale 1ns/100ps
`default_nettype none
module chp_card_end #(
  parameter int COMMON_WORDS = 64
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  chp_link_if.device         link,
  input  wire logic          core_busy,
  input  wire logic          irq_pending,
  input  wire logic          dma_want,
  output logic               dma_go,
  output logic               card_in_reset,
  output chp_pkg::chp_mode_type mode_out
);
  import chp_pkg::*;

  localparam int CW = $clog2(COMMON_WORDS);
  logic                strap_done_r;
  logic                ide_r;
  logic                seen_idle_r;
  logic                pin_rst;
  logic [7:0]          cor_r;
  logic [15:0]         busy_r;
  logic                ready;
  chp_mode_type        mode_c;
  logic                we_n_d_r;
  logic [ADDR_W-1:0]   wa_r;
  logic [DATA_W-1:0]   wd_r;
  logic                wreg_n_r;
  logic                wr_evt;
  logic                rd_ok;
  logic [DATA_W-1:0]   rd_data;
  logic [DATA_W-1:0]   common_mem [COMMON_WORDS];
  logic                irq_d_r;
  logic [7:0]          pulse_r;
  logic                rb_nxt;
  logic [DATA_W-1:0]   d_card_r;
  logic                d_card_oe_r;
  logic                rb_r;
  logic                ide_interrupt_request_r;
  logic                dma_request_out_r;
  logic                dma_go_r;
  logic                in_rst_r;
  chp_mode_type        mode_r;

  // arbitrary tuple bytes; real content comes from the product build
  function automatic logic [7:0] cis_byte(input logic [2:0] idx);
    case (idx)
      3'h0:    cis_byte = 8'h01;
      3'h1:    cis_byte = 8'h03;
      3'h2:    cis_byte = 8'hD9;
      3'h3:    cis_byte = 8'h01;
      3'h4:    cis_byte = 8'hFF;
      3'h5:    cis_byte = 8'h1C;
      default: cis_byte = 8'hFF;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] attr_read(input logic [ADDR_W-1:0] a, input logic [7:0] cor,
                                                  input logic intr);
    attr_read = 16'h00FF;
    if (a == COR_ADDR) begin
      attr_read = {8'h00, cor};
    end else if (a == CSR_ADDR) begin
      attr_read = {8'h00, 6'h00, intr, 1'b0};
    end else if (a < ADDR_W'(2 * CIS_WORDS) && !a[0]) begin
      attr_read = {8'h00, cis_byte(a[3:1])};
    end
  endfunction

  // strap caught once after release, never under the async reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      ide_r        <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ide_r        <= !link.ide_mode_select_n;
    end
  end

  // a pin held high from power-up only gives the power-up reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_idle_r <= 1'b0;
    end else if (!link.card_reset) begin
      seen_idle_r <= 1'b1;
    end
  end

  always_comb begin
    if (ide_r) begin
      pin_rst = !link.card_reset;
    end else begin
      pin_rst = link.card_reset && seen_idle_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 16'(RST_PROC_CYC);
    end else if (pin_rst || cor_r[COR_SRST_BIT] || !strap_done_r) begin
      busy_r <= 16'(RST_PROC_CYC);
    end else if (busy_r != 16'h0000) begin
      busy_r <= busy_r - 16'h0001;
    end
  end

  assign ready = (busy_r == 16'h0000);
  always_comb begin
    if (ide_r) begin
      mode_c = CHP_IDE;
    end else if (cor_r[COR_IDX_MSB:0] != 6'h00) begin
      mode_c = CHP_IO;
    end else begin
      mode_c = CHP_MEM;
    end
  end

  // write data is latched while strobed, used on the trailing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      we_n_d_r <= 1'b1;
      wa_r     <= '0;
      wd_r     <= '0;
      wreg_n_r <= 1'b1;
    end else begin
      we_n_d_r <= link.we_n;
      if (!link.ce_n && !link.we_n) begin
        wa_r     <= link.addr;
        wd_r     <= link.d_bus;
        wreg_n_r <= link.reg_n;
      end
    end
  end

  assign wr_evt = !we_n_d_r && link.we_n && ready && !ide_r;

  // soft reset keeps itself set until a pin reset clears it; COR writes are refused while it holds the card busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cor_r <= COR_RST;
    end else if (pin_rst) begin
      cor_r <= COR_RST;
    end else if (wr_evt && !wreg_n_r && wa_r == COR_ADDR) begin
      cor_r <= wd_r[7:0];
    end else if (cor_r[COR_SRST_BIT]) begin
      cor_r[COR_SRST_BIT-1:0] <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_evt && wreg_n_r && mode_c == CHP_MEM) begin
      common_mem[wa_r[CW-1:0]] <= wd_r;
    end
  end

  // no common or task-file reads through this strobe in i/o or ide mode
  always_comb begin
    rd_ok = !link.ce_n && !link.oe_n && ready;
    case (mode_c)
      CHP_MEM: rd_ok = rd_ok;
      CHP_IO:  rd_ok = rd_ok && !link.reg_n;
      CHP_IDE: rd_ok = 1'b0;
      default: rd_ok = 1'b0;
    endcase
    if (link.reg_n) begin
      rd_data = common_mem[link.addr[CW-1:0]];
    end else begin
      rd_data = attr_read(link.addr, cor_r, irq_pending);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_card_oe_r <= 1'b0;
      d_card_r    <= '0;
    end else begin
      d_card_oe_r <= rd_ok;
      d_card_r    <= rd_ok ? rd_data : '0;
    end
  end

  // pulse mode: one fixed low pulse per rising request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_d_r <= 1'b0;
      pulse_r <= 8'h00;
    end else begin
      irq_d_r <= irq_pending;
      if (irq_pending && !irq_d_r && mode_c == CHP_IO && !cor_r[COR_LVL_BIT]) begin
        pulse_r <= 8'(IRQ_PULSE_CYC);
      end else if (pulse_r != 8'h00) begin
        pulse_r <= pulse_r - 8'h01;
      end
    end
  end

  always_comb begin
    case (mode_c)
      CHP_MEM: rb_nxt = ready && !core_busy;
      CHP_IO:  rb_nxt = cor_r[COR_LVL_BIT] ? !irq_pending : (pulse_r == 8'h00);
      CHP_IDE: rb_nxt = 1'b1;
      default: rb_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_r    <= 1'b0;
      ide_interrupt_request_r <= 1'b0;
    end else begin
      rb_r    <= rb_nxt;
      ide_interrupt_request_r <= ide_r && ready && irq_pending;
    end
  end

  // request follows dma_want while ready in ide; the grant neither holds nor drops it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_request_out_r  <= 1'b0;
      dma_go_r <= 1'b0;
    end else begin
      dma_request_out_r  <= ide_r && ready && dma_want;
      dma_go_r <= dma_request_out_r && !link.dma_grant_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_rst_r <= 1'b1;
      mode_r   <= CHP_MEM;
    end else begin
      in_rst_r <= !ready;
      mode_r   <= mode_c;
    end
  end

  assign link.d_card                = d_card_r;
  assign link.d_card_oe             = d_card_oe_r;
  assign link.ready_busy_n          = rb_r;
  assign link.ide_interrupt_request = ide_interrupt_request_r;
  assign link.dma_request_out       = dma_request_out_r;
  assign dma_go                     = dma_go_r;
  assign card_in_reset              = in_rst_r;
  assign mode_out                   = mode_r;
endmodule
`default_nettype wire

// file: verilog/chp_host_end.sv
/*
  chp_host_end: host controller for the card port. Software drives it over
  Avalon-MM with waitrequest; it runs strobed cycles, the reset and mode
  pins and the dma grant. Assumes the card end on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module chp_host_end (
  input  wire logic          clk,
  input  wire logic          rst_n,
  chp_link_if.host           link,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output logic               irq
);
  import chp_pkg::*;

  chp_hstate_type     st_r;
  logic [7:0]         cnt_r;
  logic [3:0]         ctrl_r;
  logic [16:0]        addr_r;
  logic [DATA_W-1:0]  wdata_r;
  logic [DATA_W-1:0]  rdata_r;
  logic               is_wr_r;
  logic               wait_r;
  logic [31:0]        rd_r;
  logic               acc;
  logic               start;
  logic [IRQ_W-1:0]   sts_r;
  logic [IRQ_W-1:0]   msk_r;
  logic [IRQ_W-1:0]   evt;
  logic               rb_d_r;
  logic               ide_interrupt_request_d_r;
  logic               dma_request_out_d_r;
  logic               done_p;
  logic               irq_r;
  logic               ce_n_r;
  logic               oe_n_r;
  logic               we_n_r;
  logic               reg_n_r;
  logic               dho_r;
  logic               dma_grant_n_n_r;

  assign acc   = (avs_read || avs_write) && !wait_r;
  assign start = acc && avs_write && avs_address == H_CMD && st_r == HS_IDLE;

  // one wait cycle, then a single-cycle answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rd_r   <= '0;
    end else if ((avs_read || avs_write) && wait_r) begin
      wait_r <= 1'b0;
      case (avs_address)
        H_CTRL:  rd_r <= {28'h0, ctrl_r};
        H_ADDR:  rd_r <= {15'h0, addr_r};
        H_WDATA: rd_r <= {16'h0, wdata_r};
        H_STAT:  rd_r <= {rdata_r, 12'h0, link.dma_request_out, link.ide_interrupt_request,
                          link.ready_busy_n, st_r != HS_IDLE};
        H_IRQS:  rd_r <= {28'h0, sts_r};
        H_IRQM:  rd_r <= {28'h0, msk_r};
        default: rd_r <= '0;
      endcase
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RST;
      addr_r  <= '0;
      wdata_r <= '0;
      msk_r   <= '0;
    end else if (acc && avs_write) begin
      case (avs_address)
        H_CTRL:  ctrl_r  <= avs_writedata[3:0];
        H_ADDR:  addr_r  <= avs_writedata[16:0];
        H_WDATA: wdata_r <= avs_writedata[15:0];
        H_IRQM:  msk_r   <= avs_writedata[IRQ_W-1:0];
        default: ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // cycle sequencer; busy card is waited for, not refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= HS_IDLE;
      cnt_r   <= 8'h00;
      is_wr_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      case (st_r)
        HS_IDLE: if (start) begin
          is_wr_r <= avs_writedata[CMD_WR_BIT];
          if (avs_writedata[CMD_WR_BIT] || avs_writedata[CMD_RD_BIT]) begin
            st_r <= HS_WAIT;
          end
        end
        HS_WAIT: if (link.ready_busy_n || ctrl_r[CTRL_IO_BIT] || ctrl_r[CTRL_IDE_BIT]) begin
          st_r  <= HS_SETUP;
          cnt_r <= 8'(SETUP_CYC);
        end
        HS_SETUP: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            st_r  <= HS_STROBE;
            cnt_r <= 8'(STROBE_CYC);
          end
        end
        HS_STROBE: begin
          cnt_r <= cnt_r - 8'h01;
          if (cnt_r == 8'h01) begin
            st_r <= HS_HOLD;
            if (!is_wr_r) begin
              rdata_r <= link.d_bus;
            end
          end
        end
        HS_HOLD: st_r <= HS_IDLE;
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  assign done_p = (st_r == HS_HOLD);
  assign evt = {link.dma_request_out && !dma_request_out_d_r,
                link.ide_interrupt_request && !ide_interrupt_request_d_r,
                ctrl_r[CTRL_IO_BIT] && rb_d_r && !link.ready_busy_n,
                done_p};

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sts_r     <= '0;
      rb_d_r    <= 1'b0;
      ide_interrupt_request_d_r <= 1'b0;
      dma_request_out_d_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      rb_d_r    <= link.ready_busy_n;
      ide_interrupt_request_d_r <= link.ide_interrupt_request;
      dma_request_out_d_r <= link.dma_request_out;
      if (acc && avs_write && avs_address == H_IRQS) begin
        sts_r <= (sts_r & ~avs_writedata[IRQ_W-1:0]) | evt;
      end else begin
        sts_r <= sts_r | evt;
      end
      irq_r <= |(sts_r & msk_r);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n_r    <= 1'b1;
      oe_n_r    <= 1'b1;
      we_n_r    <= 1'b1;
      reg_n_r   <= 1'b1;
      dho_r     <= 1'b0;
      dma_grant_n_n_r <= 1'b1;
    end else begin
      ce_n_r    <= !(st_r == HS_SETUP || st_r == HS_STROBE);
      oe_n_r    <= !(st_r == HS_SETUP && cnt_r == 8'h01 && !is_wr_r) &&
                   !(st_r == HS_STROBE && cnt_r != 8'h01 && !is_wr_r);
      we_n_r    <= !(st_r == HS_SETUP && cnt_r == 8'h01 && is_wr_r) &&
                   !(st_r == HS_STROBE && cnt_r != 8'h01 && is_wr_r);
      reg_n_r   <= !(ctrl_r[CTRL_IO_BIT] || addr_r[ADDR_ATTR_BIT]);
      dho_r     <= is_wr_r && (st_r == HS_SETUP || st_r == HS_STROBE);
      dma_grant_n_n_r <= !(ctrl_r[CTRL_DMA_BIT] && link.dma_request_out);
    end
  end

  assign link.ce_n              = ce_n_r;
  assign link.oe_n              = oe_n_r;
  assign link.we_n              = we_n_r;
  assign link.reg_n             = reg_n_r;
  assign link.addr              = addr_r[ADDR_W-1:0];
  assign link.d_host            = wdata_r;
  assign link.d_host_oe         = dho_r;
  assign link.card_reset        = ctrl_r[CTRL_RST_BIT];
  assign link.ide_mode_select_n = !ctrl_r[CTRL_IDE_BIT];
  assign link.dma_grant_n       = dma_grant_n_n_r;
  assign avs_readdata           = rd_r;
  assign avs_waitrequest        = wait_r;
  assign irq                    = irq_r;
endmodule
`default_nettype wire

// file: dv/chp_link_monitor.sv
/*
  chp_link_monitor: assertions on the pins between host end and card end.
  Assumes one clock and the card end's reset on rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module chp_link_monitor (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce_n,
  input  wire logic oe_n,
  input  wire logic card_reset,
  input  wire logic ide_mode_select_n,
  input  wire logic dma_grant_n,
  input  wire logic d_card_oe,
  input  wire logic ready_busy_n,
  input  wire logic ide_interrupt_request,
  input  wire logic dma_request_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic pin_was_low_r;

  // a pin high ever since release must not reset the card again
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_was_low_r <= 1'b0;
    end else if (!card_reset) begin
      pin_was_low_r <= 1'b1;
    end
  end

  // card drive lags the strobe by one cycle, so look one cycle back
  a_drive_when_read: assert property (d_card_oe |-> !$past(ce_n) && !$past(oe_n))
    else $error("card drives data bus outside a selected read");
  a_strobe_selected: assert property (!oe_n |-> !ce_n)
    else $error("read strobe low without card select");
  a_strobe_width: assert property ($fell(oe_n) |-> !oe_n [*4] ##1 oe_n)
    else $error("read strobe width wrong");
  a_busy_on_release: assert property ($rose(rst_n) && ide_mode_select_n |-> !ready_busy_n [*8])
    else $error("ready shown too soon after reset");
  a_ready_in_bound: assert property ($rose(rst_n) && ide_mode_select_n && !card_reset |->
    ##45 !ready_busy_n ##[1:15] ready_busy_n)
    else $error("reset processing length wrong");
  a_pin_reset_busy: assert property (card_reset && $past(card_reset, 3) && pin_was_low_r &&
    ide_mode_select_n |-> !ready_busy_n)
    else $error("high reset pin did not hold card busy");
  a_ide_reset_quiet: assert property (!card_reset && !$past(card_reset, 3) && !ide_mode_select_n &&
    !$past(ide_mode_select_n, 3) |-> !dma_request_out)
    else $error("dma request during low reset pin in ide");
  a_grant_after_req: assert property ($fell(dma_grant_n) |-> $past(dma_request_out))
    else $error("grant given without a pending request");
  a_dma_request_out_ide_only: assert property (dma_request_out |-> !ide_mode_select_n)
    else $error("dma request outside ide mode");
  a_ide_irq_only: assert property (ide_interrupt_request |-> !ide_mode_select_n)
    else $error("ide interrupt outside ide mode");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
/*
  tb_top: self-checking bench, host end and card end joined by the link.
  Assumes the designer's package; software side is Avalon-MM.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import chp_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         card_rst_n;
  logic [4:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic         irq;
  logic         core_busy;
  logic         irq_pending;
  logic         dma_want;
  logic         dma_go;
  logic         card_in_reset;
  chp_mode_type mode_out;
  int           bad_count;
  int           cmp_count;
  logic [31:0]  rd;
  int           n;

  chp_link_if link();
  chp_host_end chp_host_end_i (.clk(clk), .rst_n(rst_n), .link(link), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  chp_card_end chp_card_end_i (.clk(clk), .rst_n(card_rst_n), .link(link), .core_busy(core_busy),
    .irq_pending(irq_pending), .dma_want(dma_want), .dma_go(dma_go),
    .card_in_reset(card_in_reset), .mode_out(mode_out));
  chp_link_monitor chp_link_monitor_i (.clk(clk), .rst_n(card_rst_n), .ce_n(link.ce_n), .oe_n(link.oe_n),
    .card_reset(link.card_reset), .ide_mode_select_n(link.ide_mode_select_n),
    .dma_grant_n(link.dma_grant_n), .d_card_oe(link.d_card_oe), .ready_busy_n(link.ready_busy_n),
    .ide_interrupt_request(link.ide_interrupt_request), .dma_request_out(link.dma_request_out));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one spare edge after release so the next request never lands in the same step
  task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (k >= 100) check(32'h0, 32'h1);
  endtask

  task automatic pin_cycle(input logic [31:0] a, input logic [31:0] cmd, input logic [15:0] wd);
    int k;
    k = 0;
    av_xfer(1'b1, H_ADDR, a);
    av_xfer(1'b1, H_WDATA, {16'h0000, wd});
    av_xfer(1'b1, H_IRQS, 32'h1);
    av_xfer(1'b1, H_CMD, cmd);
    av_xfer(1'b0, H_IRQS, 32'h0);
    while (rd[0] !== 1'b1 && k < 200) begin
      av_xfer(1'b0, H_IRQS, 32'h0);
      k++;
    end
    check(32'(rd[0]), 32'h1);
  endtask

  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    while (link.ready_busy_n !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_power_up();
    check(32'(link.ready_busy_n), 32'h0);
    wait_pin(1'b1, 200);
    check(32'(n >= RST_PROC_CYC - 2 && n <= RST_PROC_CYC + 6), 32'h1);
    av_xfer(1'b0, H_STAT, 32'h0);
    check(32'(rd[1]), 32'h1);
    av_xfer(1'b0, 5'h1C, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_mem_rw();
    core_busy <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(link.ready_busy_n), 32'h0);
    core_busy <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(link.ready_busy_n), 32'h1);
    av_xfer(1'b1, H_IRQM, 32'h1);
    pin_cycle(32'h0000_0010, 32'h2, 16'hA5C3);
    check(32'(irq), 32'h1);
    pin_cycle(32'h0000_0010, 32'h1, 16'h0000);
    av_xfer(1'b0, H_STAT, 32'h0);
    check(32'(rd[31:16]), 32'hA5C3);
    check(32'(link.d_bus), 32'hFFFF);
    irq_pending <= 1'b1;
    pin_cycle(32'h0001_0202, 32'h1, 16'h0000);
    av_xfer(1'b0, H_STAT, 32'h0);
    check(32'(rd[17]), 32'h1);
    check(32'(link.ready_busy_n), 32'h1);
    irq_pending <= 1'b0;
    av_xfer(1'b1, H_IRQS, 32'h1);
    av_xfer(1'b1, H_IRQM, 32'h0);
    check(32'(irq), 32'h0);
    pin_cycle(32'h0000_0010, 32'h1, 16'h0000);
    check(32'(irq), 32'h0);
  endtask

  task automatic t_io_irq();
    pin_cycle(32'h0001_0200, 32'h2, 16'h0001);
    av_xfer(1'b1, H_CTRL, 32'h4);
    irq_pending <= 1'b1;
    wait_pin(1'b0, 20);
    wait_pin(1'b1, 20);
    check(32'(n), 32'(IRQ_PULSE_CYC));
    irq_pending <= 1'b0;
    pin_cycle(32'h0001_0200, 32'h2, 16'h0041);
    irq_pending <= 1'b1;
    repeat (12) @(posedge clk);
    check(32'(link.ready_busy_n), 32'h0);
    av_xfer(1'b0, H_IRQS, 32'h0);
    check(32'(rd[1]), 32'h1);
    irq_pending <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(link.ready_busy_n), 32'h1);
    // common read while configured for i/o must find the bus undriven
    av_xfer(1'b1, H_CTRL, 32'h0);
    pin_cycle(32'h0000_0010, 32'h1, 16'h0000);
    av_xfer(1'b0, H_STAT, 32'h0);
    check(32'(rd[31:16]), 32'hFFFF);
  endtask

  task automatic t_resets();
    pin_cycle(32'h0001_0200, 32'h2, 16'h0080);
    repeat (3) @(posedge clk);
    check(32'(card_in_reset), 32'h1);
    av_xfer(1'b1, H_CTRL, 32'h2);
    repeat (5) @(posedge clk);
    check(32'(card_in_reset), 32'h1);
    av_xfer(1'b1, H_CTRL, 32'h0);
    wait_pin(1'b1, 100);
    check(32'(card_in_reset), 32'h0);
    // pin already high when the card comes out of reset: power-up reset only
    av_xfer(1'b1, H_CTRL, 32'h2);
    card_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    card_rst_n <= 1'b1;
    wait_pin(1'b1, 100);
    repeat (20) @(posedge clk);
    check(32'(link.ready_busy_n), 32'h1);
    check(32'(card_in_reset), 32'h0);
  endtask

  // ide is strapped at card reset release, so pulse only the card's reset
  task automatic t_ide();
    av_xfer(1'b1, H_CTRL, 32'hB);
    card_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    card_rst_n <= 1'b1;
    dma_want <= 1'b1;
    repeat (80) @(posedge clk);
    check(32'(mode_out), 32'(CHP_IDE));
    check(32'(link.ready_busy_n), 32'h1);
    check(32'(dma_go), 32'h1);
    check(32'(link.dma_grant_n), 32'h0);
    irq_pending <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(link.ide_interrupt_request), 32'h1);
    av_xfer(1'b0, H_IRQS, 32'h0);
    check(32'(rd[3:2]), 32'h3);
    av_xfer(1'b1, H_CTRL, 32'h9);
    repeat (4) @(posedge clk);
    check(32'(card_in_reset), 32'h1);
    check(32'(link.dma_request_out), 32'h0);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // whole run is well under 1000 cycles; 50000 means a hang
  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    card_rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    core_busy = 1'b0;
    irq_pending = 1'b0;
    dma_want = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    card_rst_n <= 1'b1;
    @(posedge clk);
    t_power_up();
    t_mem_rw();
    t_io_irq();
    t_resets();
    t_ide();
    give_verdict();
  end
endmodule
`default_nettype wire
